/* File: rtl/itio_defs.vh */
// constants for the interval timer and io port block
`ifndef ITIO_DEFS_VH
`define ITIO_DEFS_VH
`define ITIO_ADDR_PORTA      10'h280
`define ITIO_ADDR_PORTA_DIR  10'h281
`define ITIO_ADDR_SWITCH     10'h282
`define ITIO_ADDR_SWITCH_DIR 10'h283
`define ITIO_ADDR_TIMER      10'h284
`define ITIO_ADDR_IRQ_STAT   10'h285
`define ITIO_ADDR_IRQ_MASK   10'h286
`define ITIO_ADDR_LOAD_DIV1  10'h294
`define ITIO_ADDR_LOAD_DIV8  10'h295
`define ITIO_ADDR_LOAD_DIV64 10'h296
`define ITIO_ADDR_LOAD_DIV1K 10'h297
`define ITIO_RAM_BASE        10'h080
`define ITIO_RAM_TOP         10'h0ff
`define ITIO_SEL_DIV1        2'h0
`define ITIO_SEL_DIV8        2'h1
`define ITIO_SEL_DIV64       2'h2
`define ITIO_SEL_DIV1K       2'h3
`define ITIO_DIV1_LAST       10'h000
`define ITIO_DIV8_LAST       10'h007
`define ITIO_DIV64_LAST      10'h03f
`define ITIO_DIV1K_LAST      10'h3ff
`define ITIO_SWITCH_UNUSED   8'h34
`define ITIO_DIR_ALL_IN      8'h00
`define ITIO_IRQ_ZERO_BIT    0
`define ITIO_IRQ_LOAD_BIT    1
`endif

/* File: rtl/itio_ram.v */
// scratch ram of the interval timer and io port block
module itio_ram #(
   parameter DEPTH  = 128,
   parameter AWIDTH = 7
) (
   // clock
   input  wire              i_sys_clk,
   // access
   input  wire              i_write,
   input  wire [AWIDTH-1:0] i_addr,
   input  wire [7:0]        i_wdata,
   output reg  [7:0]        o_rdata
);
   reg [7:0] mem [0:DEPTH-1];

   // contents not cleared by reset, as in the original part
   always @(posedge i_sys_clk) begin
      if (i_write) begin
         mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_addr];
   end
endmodule // itio_ram

/* File: rtl/itio_top.v */
// interval timer, scratch ram and two parallel ports
//
// Overview of operation
// - prescaler counts one per system clock
// - four load addresses select interval 1/8/64/1024
// - count decrements once per full interval
// - hold zero one interval, wrap, fast count
// - reading count never disturbs the timer
// - 128 byte ram at 80 through ff
// - port a direction register, 1 means output
// - port a drives outputs, reads input pin levels and output drive
// - switch port input only, direction reads zero
// - switch port bit layout of console switches
// - port a inputs carry both joysticks
// - paddle triggers on port a 7,6,3,2
// - load addresses 294 to 297 decoded
`include "itio_defs.vh"
module itio_top #(
   parameter RAM_DEPTH = 128,
   parameter RAM_AW    = 7
) (
   // clock and reset
   input  wire       i_sys_clk,
   input  wire       i_reset,
   // register port
   input  wire [9:0] i_addr,
   input  wire [7:0] i_wdata,
   input  wire       i_write,
   input  wire       i_read,
   output reg  [7:0] o_rdata,
   // port a pins, joysticks, paddle triggers, keypad rows
   input  wire [7:0] i_port_a_pins,
   output reg  [7:0] o_port_a_pins,
   output reg  [7:0] o_port_a_oe,
   // console switches
   input  wire       i_right_player_pro,
   input  wire       i_left_player_pro,
   input  wire       i_colour,
   input  wire       i_select_n,
   input  wire       i_game_reset_n,
   // interrupt
   output wire       o_irq
);
   // address decode used at several places
   function is_addr;
      input [9:0] a;
      input [9:0] b;
      begin
         is_addr = (a == b);
      end
   endfunction

   // two stage synchronisers for every pin input
   localparam PA_WIDTH = 8;
   localparam SW_WIDTH = 5;
   reg  [PA_WIDTH-1:0] pa_meta;
   reg  [PA_WIDTH-1:0] pa_sync;
   reg  [SW_WIDTH-1:0] sw_meta;
   reg  [SW_WIDTH-1:0] sw_sync;
   wire [SW_WIDTH-1:0] sw_raw;
   genvar              gi;
   assign sw_raw = {i_right_player_pro, i_left_player_pro, i_colour,
                    i_select_n, i_game_reset_n};
   // only the second stage is read, the first may still be settling
   generate
      for (gi = 0; gi < PA_WIDTH; gi = gi + 1) begin : g_pa_sync
         always @(posedge i_sys_clk) begin
            pa_meta[gi] <= i_port_a_pins[gi];
            pa_sync[gi] <= pa_meta[gi];
         end
      end
      for (gi = 0; gi < SW_WIDTH; gi = gi + 1) begin : g_sw_sync
         always @(posedge i_sys_clk) begin
            sw_meta[gi] <= sw_raw[gi];
            sw_sync[gi] <= sw_meta[gi];
         end
      end
   endgenerate

   // switch port image, unused bits read zero
   wire [7:0] switch_image;
   wire       right_pro;
   wire       left_pro;
   wire       colour;
   wire       select_n;
   wire       game_reset_n;
   assign right_pro    = sw_sync[4];
   assign left_pro     = sw_sync[3];
   assign colour       = sw_sync[2];
   assign select_n     = sw_sync[1];
   assign game_reset_n = sw_sync[0];
   assign switch_image = {right_pro, left_pro, 2'b00, colour, 1'b0,
                          select_n, game_reset_n};

   // write decode
   wire load_div1;
   wire load_div8;
   wire load_div64;
   wire load_div1k;
   wire timer_load;
   wire in_ram;
   assign load_div1  = i_write & is_addr(i_addr, `ITIO_ADDR_LOAD_DIV1);
   assign load_div8  = i_write & is_addr(i_addr, `ITIO_ADDR_LOAD_DIV8);
   assign load_div64 = i_write & is_addr(i_addr, `ITIO_ADDR_LOAD_DIV64);
   assign load_div1k = i_write & is_addr(i_addr, `ITIO_ADDR_LOAD_DIV1K);
   assign timer_load = load_div1 | load_div8 | load_div64 | load_div1k;
   assign in_ram     = (i_addr >= `ITIO_RAM_BASE) && (i_addr <= `ITIO_RAM_TOP);

   wire wr_porta;
   wire wr_dir;
   wire wr_irq_stat;
   wire wr_irq_mask;
   assign wr_porta    = i_write & is_addr(i_addr, `ITIO_ADDR_PORTA);
   assign wr_dir      = i_write & is_addr(i_addr, `ITIO_ADDR_PORTA_DIR);
   assign wr_irq_stat = i_write & is_addr(i_addr, `ITIO_ADDR_IRQ_STAT);
   assign wr_irq_mask = i_write & is_addr(i_addr, `ITIO_ADDR_IRQ_MASK);

   // port a registers, one slice per pin
   localparam [PA_WIDTH-1:0] DIR_RESET = `ITIO_DIR_ALL_IN;
   reg        [PA_WIDTH-1:0] port_a_direction;

   generate
      for (gi = 0; gi < PA_WIDTH; gi = gi + 1) begin : g_pa_pin
         always @(posedge i_sys_clk) begin
            if (i_reset) begin
               port_a_direction[gi] <= DIR_RESET[gi];
               o_port_a_pins[gi]    <= 1'b0;
               o_port_a_oe[gi]      <= 1'b0;
            end else begin
               if (wr_dir) begin
                  port_a_direction[gi] <= i_wdata[gi];
               end
               // latch holds for input pins too, appears once switched out
               if (wr_porta) begin
                  o_port_a_pins[gi] <= i_wdata[gi];
               end
               o_port_a_oe[gi] <= wr_dir ? i_wdata[gi] : port_a_direction[gi];
            end
         end
      end
   endgenerate

   // interval timer
   reg  [7:0] timer_count;
   reg  [9:0] prescale;
   reg  [1:0] interval_sel;
   reg        fast_mode;
   reg  [9:0] interval_last;
   wire       tick;
   wire       underflow;
   // last prescaler value of each interval
   function [9:0] interval_end;
      input [1:0] sel;
      begin
         case (sel)
            `ITIO_SEL_DIV1:  interval_end = `ITIO_DIV1_LAST;
            `ITIO_SEL_DIV8:  interval_end = `ITIO_DIV8_LAST;
            `ITIO_SEL_DIV64: interval_end = `ITIO_DIV64_LAST;
            `ITIO_SEL_DIV1K: interval_end = `ITIO_DIV1K_LAST;
            default:         interval_end = `ITIO_DIV1_LAST;
         endcase
      end
   endfunction

   // interval select encoded from the load address that was hit
   function [1:0] load_select;
      input d1;
      input d8;
      input d64;
      begin
         if (d1) begin
            load_select = `ITIO_SEL_DIV1;
         end else if (d8) begin
            load_select = `ITIO_SEL_DIV8;
         end else if (d64) begin
            load_select = `ITIO_SEL_DIV64;
         end else begin
            load_select = `ITIO_SEL_DIV1K;
         end
      end
   endfunction

   wire       interval_done;
   always @* begin
      interval_last = interval_end(interval_sel);
   end
   // tick ends each full interval of system clocks
   assign interval_done = (prescale == interval_last);
   assign tick          = fast_mode | interval_done;
   // zero already held one interval when a tick finds it
   assign underflow = tick & (timer_count == 8'h00) & ~fast_mode;

   reg  [7:0] next_timer_count;
   reg  [9:0] next_prescale;
   reg  [1:0] next_interval_sel;
   reg        next_fast_mode;
   always @* begin
      next_timer_count  = timer_count;
      next_prescale     = prescale;
      next_interval_sel = interval_sel;
      next_fast_mode    = fast_mode;
      if (timer_load) begin
         // start count 1..255 is software's duty; 0 just underflows soon
         next_timer_count  = i_wdata;
         next_prescale     = 10'h000;
         next_fast_mode    = 1'b0;
         next_interval_sel = load_select(load_div1, load_div8, load_div64);
      end else begin
         next_prescale = tick ? 10'h000 : prescale + 10'h001;
         if (tick) begin
            next_timer_count = timer_count - 8'h01;
         end
         if (underflow) begin
            next_fast_mode = 1'b1;
         end
      end
   end

   // the count moves only on loads and ticks, never on reads
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         timer_count  <= 8'h00;
         prescale     <= 10'h000;
         interval_sel <= `ITIO_SEL_DIV1;
         fast_mode    <= 1'b0;
      end else begin
         timer_count  <= next_timer_count;
         prescale     <= next_prescale;
         interval_sel <= next_interval_sel;
         fast_mode    <= next_fast_mode;
      end
   end

   // scratch ram
   wire [7:0] ram_rdata;
   wire       ram_write;
   assign ram_write = i_write & in_ram;
   itio_ram #(
      .DEPTH  (RAM_DEPTH),
      .AWIDTH (RAM_AW)
   ) u_ram (
      .i_sys_clk (i_sys_clk),
      .i_write   (ram_write),
      .i_addr    (i_addr[RAM_AW-1:0]),
      .i_wdata   (i_wdata),
      .o_rdata   (ram_rdata)
   );

   // interrupt status: bit0 timer underflow, bit1 timer loaded
   reg  [1:0] irq_status;
   reg  [1:0] irq_mask;
   wire [1:0] irq_events;
   wire [1:0] irq_clear;
   wire       evt_underflow;
   wire       evt_load;
   assign evt_underflow = underflow;
   assign evt_load      = timer_load;
   assign irq_events = {evt_load, evt_underflow};
   assign irq_clear  = wr_irq_stat ? i_wdata[1:0] : 2'b00;

   // status bits stay set until software writes a one
   localparam IRQ_WIDTH = 2;
   generate
      for (gi = 0; gi < IRQ_WIDTH; gi = gi + 1) begin : g_irq_bit
         always @(posedge i_sys_clk) begin
            if (i_reset) begin
               irq_status[gi] <= 1'b0;
               irq_mask[gi]   <= 1'b0;
            end else begin
               // a new event beats a clear in the same cycle
               if (irq_events[gi]) begin
                  irq_status[gi] <= 1'b1;
               end else if (irq_clear[gi]) begin
                  irq_status[gi] <= 1'b0;
               end
               if (wr_irq_mask) begin
                  irq_mask[gi] <= i_wdata[gi];
               end
            end
         end
      end
   endgenerate
   assign o_irq = |(irq_status & irq_mask);

   // read path, data one cycle after the strobe
   reg       read_q;
   reg       ram_sel_q;
   reg [7:0] read_hold;
   wire [7:0] pa_read;
   // output pins read back their own drive, inputs their sampled level
   generate
      for (gi = 0; gi < PA_WIDTH; gi = gi + 1) begin : g_pa_read
         assign pa_read[gi] = port_a_direction[gi] ? o_port_a_pins[gi] :
                              pa_sync[gi];
      end
   endgenerate

   // the bus never waits, so every readable value is ready in one cycle
   reg  [7:0] next_read_hold;
   always @* begin
      case (i_addr)
         `ITIO_ADDR_PORTA:      next_read_hold = pa_read;
         `ITIO_ADDR_SWITCH:     next_read_hold = switch_image;
         `ITIO_ADDR_SWITCH_DIR: next_read_hold = `ITIO_DIR_ALL_IN;
         `ITIO_ADDR_TIMER:      next_read_hold = timer_count;
         `ITIO_ADDR_IRQ_STAT:   next_read_hold = {6'h00, irq_status};
         `ITIO_ADDR_IRQ_MASK:   next_read_hold = {6'h00, irq_mask};
         default:               next_read_hold = 8'h00;
      endcase
   end

   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         read_q    <= 1'b0;
         ram_sel_q <= 1'b0;
         read_hold <= 8'h00;
      end else begin
         read_q    <= i_read;
         ram_sel_q <= i_read & in_ram;
         if (i_read) begin
            read_hold <= next_read_hold;
         end
      end
   end
   always @* begin
      if (!read_q) begin
         o_rdata = 8'h00;
      end else if (ram_sel_q) begin
         o_rdata = ram_rdata;
      end else begin
         o_rdata = read_hold;
      end
   end
endmodule // itio_top

/* File: tb/itio_assertions.sv */
// port assertions of the interval timer and io block
`include "itio_defs.vh"
module itio_checker (
   // clock and reset
   input logic       i_sys_clk,
   input logic       i_reset,
   // register port and port a outputs
   input logic [9:0] i_addr,
   input logic [7:0] i_wdata,
   input logic       i_write,
   input logic       i_read,
   input logic [7:0] o_rdata,
   input logic [7:0] o_port_a_pins,
   input logic [7:0] o_port_a_oe
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   wire wr_dir = i_write && i_addr == `ITIO_ADDR_PORTA_DIR;
   wire wr_pa  = i_write && i_addr == `ITIO_ADDR_PORTA;
   wire rd_tim = i_read && i_addr == `ITIO_ADDR_TIMER;
   wire ld_1k  = i_write && i_addr == `ITIO_ADDR_LOAD_DIV1K;
   wire ld_sl  = i_write && i_addr > `ITIO_ADDR_LOAD_DIV1 && i_addr <= `ITIO_ADDR_LOAD_DIV1K;
   wire wr_ram = i_write && i_addr[9:7] == 3'h1;
   wire rd_a   = i_read && i_addr == `ITIO_ADDR_PORTA && o_port_a_oe == 8'hff;
   // div1 left out: its first tick may land on the read edge
   a_dir_write: assert property (wr_dir |=> o_port_a_oe == $past(i_wdata))
      else $error("direction not loaded");
   a_pin_write: assert property (wr_pa |=> o_port_a_pins == $past(i_wdata))
      else $error("port latch not loaded");
   a_pin_readback: assert property (rd_a |=> o_rdata == $past(o_port_a_pins))
      else $error("driven pins misread");
   a_load_visible: assert property (ld_sl ##1 rd_tim |=> o_rdata == $past(i_wdata, 2))
      else $error("load not visible");
   a_reread_steady: assert property (ld_1k ##1 rd_tim [*3] |=> o_rdata == $past(i_wdata, 4))
      else $error("reads disturb count");
   a_ram_readback: assert property (wr_ram ##1 i_read && i_addr == $past(i_addr)
      |=> o_rdata == $past(i_wdata, 2)) else $error("ram byte lost");
   a_switch_unused: assert property (i_read && i_addr == `ITIO_ADDR_SWITCH
      |=> (o_rdata & `ITIO_SWITCH_UNUSED) == 8'h00) else $error("unused bits set");
   a_switch_dir: assert property (i_read && i_addr == `ITIO_ADDR_SWITCH_DIR
      |=> o_rdata == `ITIO_DIR_ALL_IN) else $error("switch port not input");
   c_load: cover property (ld_sl ##1 rd_tim);
   c_ram: cover property (wr_ram ##1 i_read);
   c_fast: cover property (rd_tim ##1 o_rdata == 8'hff);
endmodule // itio_checker

bind itio_top itio_checker u_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
   .o_port_a_pins(o_port_a_pins), .o_port_a_oe(o_port_a_oe));

/* File: tb/itio_ctrl_model.sv */
// hand controller and keypad model on port a
module itio_ctrl_model (
   // pins from the block
   input  logic [7:0] i_drive,
   input  logic [7:0] i_oe,
   // contacts, 0 while closed
   input  logic [7:0] i_contact,
   // pin levels back to the block
   output logic [7:0] o_level
);
   // undriven pins rest on pull-ups through open contacts
   assign o_level = (i_oe & i_drive) | (~i_oe & i_contact);
endmodule // itio_ctrl_model

/* File: tb/interval_timer_io_ports_tb_top.sv */
// self-checking bench of the timer and io block
`include "itio_defs.vh"
module interval_timer_io_ports_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_sys_clk = 0, i_reset = 1, i_write = 0, i_read = 0;
   logic [9:0]  i_addr = 0;
   logic [7:0]  i_wdata = 0, cont = 8'hff, o_rdata, o_port_a_pins, o_port_a_oe, pins, a, d;
   logic [4:0]  sw = 0;
   logic        o_irq;
   logic [31:0] seed = 77355;
   int          failures = 0, check_count = 0, n, iv, k;
   always #50 i_sys_clk = ~i_sys_clk;
   itio_top dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_port_a_pins(pins),
      .o_port_a_pins(o_port_a_pins), .o_port_a_oe(o_port_a_oe), .i_right_player_pro(sw[4]),
      .i_left_player_pro(sw[3]), .i_colour(sw[2]), .i_select_n(sw[1]),
      .i_game_reset_n(sw[0]), .o_irq(o_irq));
   itio_ctrl_model u_ctrl (.i_drive(o_port_a_pins), .i_oe(o_port_a_oe), .i_contact(cont),
      .o_level(pins));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // count seen by a read taken k edges after the load edge
   function automatic logic [7:0] exp_cnt(int k, int n, int iv);
      int q;
      q = (k - 1) / iv;
      if (q <= n) return 8'(n - q);
      return 8'(255 - (k - 1 - (n + 1) * iv));
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   // strobes drop on the edge, the next raise waits 1 ns
   task automatic wr(input logic [9:0] ad, input logic [7:0] wd);
      i_write <= 1'b1;
      i_addr <= ad;
      i_wdata <= wd;
      @(posedge i_sys_clk);
      i_write <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [9:0] ad);
      i_read <= 1'b1;
      i_addr <= ad;
      @(posedge i_sys_clk);
      i_read <= 1'b0;
      #1;
   endtask
   task automatic final_report();
      if (failures == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      #9000000;
      failures++;
      final_report();
   end
   initial begin
      repeat (12) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      @(posedge i_sys_clk);
      // every load, the first too, reloads in fast mode
      for (int s = 0; s < 8; s++) begin
         iv = s % 4 == 3 ? 1024 : 1 << (3 * (s % 4));
         n = s == 0 ? 255 : iv == 1 ? xs() % 255 + 1 : xs() % 3 + 1;
         wr(`ITIO_ADDR_LOAD_DIV1 + 10'(s % 4), 8'(n));
         for (k = 1; k <= (n + 1) * iv + 8; k++) begin
            rd(`ITIO_ADDR_TIMER);
            chk(o_rdata, exp_cnt(k, n, iv));
         end
      end
      for (int s = 0; s < 6; s++) begin
         a = s == 0 ? 8'h00 : s == 1 ? 8'hff : 8'(xs());
         d = 8'(xs());
         cont <= s == 0 ? 8'hff : 8'(xs());
         wr(`ITIO_ADDR_PORTA_DIR, a);
         wr(`ITIO_ADDR_PORTA, d);
         // keypad rows settle 400 us before columns are sensed when s is 1, 3 clocks otherwise
         repeat (s == 1 ? 4000 : 3) @(posedge i_sys_clk);
         chk(o_port_a_oe, a);
         chk(o_port_a_pins, d);
         rd(`ITIO_ADDR_PORTA);
         chk(o_rdata, (a & d) | (~a & cont));
      end
      for (int s = 0; s < 4; s++) begin
         sw <= 5'(xs());
         repeat (3) @(posedge i_sys_clk);
         rd(`ITIO_ADDR_SWITCH);
         chk(o_rdata, {sw[4:3], 2'h0, sw[2], 1'h0, sw[1:0]});
         rd(`ITIO_ADDR_SWITCH_DIR);
         chk(o_rdata, `ITIO_DIR_ALL_IN);
      end
      for (int s = 0; s < 8; s++) begin
         a = s == 0 ? 8'h80 : 8'(xs()) | 8'h80;
         d = 8'(xs());
         wr({2'h0, a}, d);
         rd({2'h0, a});
         chk(o_rdata, d);
      end
      rd(10'h3ff);
      chk(o_rdata, 8'h00);
      // load event bit, masked then unmasked
      wr(`ITIO_ADDR_IRQ_MASK, 8'h00);
      wr(`ITIO_ADDR_LOAD_DIV1K, 8'h50);
      wr(`ITIO_ADDR_IRQ_STAT, 8'h03);
      rd(`ITIO_ADDR_IRQ_STAT);
      chk({7'h0, o_irq}, 8'h00);
      wr(`ITIO_ADDR_LOAD_DIV1K, 8'h50);
      rd(`ITIO_ADDR_IRQ_STAT);
      chk(o_rdata, 8'h02);
      wr(`ITIO_ADDR_IRQ_MASK, 8'h02);
      @(posedge i_sys_clk);
      chk({7'h0, o_irq}, 8'h01);
      wr(`ITIO_ADDR_IRQ_STAT, 8'h02);
      @(posedge i_sys_clk);
      chk({7'h0, o_irq}, 8'h00);
      final_report();
   end
endmodule // interval_timer_io_ports_tb_top
